//--- hw/tick_wdog_defs.vh
// constants for the periodic tick and watchdog block
// Functional notes
// R1 - tick stop-in-wait set: tick halts and reinitialises while in wait mode
// R2 - tick run-in-stop clear: tick counter freezes in stop, no reinit
// R3 - tick wait/stop bits write once in normal modes, anytime in special
// R4 - tick irq enable set: request interrupt whenever tick flag is set; code also needs irq mask bit 0
// R5 - prescale select: 00 off, 01 div 1, 10 div 16, 11 div 256
// R6 - tick period is (count select plus one) times prescaler; zero with 01 is off
// R7 - writing count select restarts the tick period; resets to zero
// R8 - tick irq enable and prescale select writable any time
// R9 - watchdog run-in-stop clear: watchdog holds value in stop, no reinit
// R10 - rate select 000 disables; 001..111 give 2^6,8,10,12,14,15,16 cycles
// R11 - nonzero rate write enables watchdog and starts a new period
// R12 - watchdog reaching its timeout generates a system reset
// R13 - software rearms the watchdog before timeout via the rearm register
// R14 - debug active, hold bit 0, special mode: force 2^16, no window mode
// R15 - tick flag sticky until software writes one; reset clears it
`ifndef TICK_WDOG_DEFS_VH
`define TICK_WDOG_DEFS_VH
`define ADDR_TICK_CONTROL 8'h3b
`define ADDR_TICK_COUNT_SELECT 8'h3d
`define ADDR_WDOG_CONTROL 8'h3c
`define ADDR_WDOG_REARM 8'h3f
`define ADDR_IRQ_STATUS 8'h40
`define ADDR_IRQ_MASK 8'h41
`define TC_STOP_IN_WAIT 4
`define TC_RUN_IN_STOP 3
`define TC_IRQ_ENABLE 2
`define WC_WINDOW 7
`define WC_STOP_IN_WAIT 6
`define WC_RUN_IN_STOP 5
`define IRQ_TICK 0
`define IRQ_WDOG 1
`define REARM_KEY1 8'h55
`define REARM_KEY2 8'haa
`define RESET_TICK_CONTROL 8'h00
`define RESET_TICK_COUNT 8'h00
`define RESET_WDOG_CONTROL 8'h00
`define WDOG_RESET_PULSE 4'h8
`endif

//--- hw/tick_prescaler.v
// prescaler that emits a one-cycle pulse every 1, 16 or 256 clocks
`timescale 1ns/10ps
module tick_prescaler (
  input wire clk,
  input wire sys_rst,
  input wire clear,
  input wire run,
  input wire [1:0] rateSel,
  output wire pulse
);
  reg [7:0] preCnt_q;
  reg [7:0] limit;

  // terminal value for each rate; off gives no pulse at all
  always @* begin
    case (rateSel)
      2'b01: limit = 8'h00;
      2'b10: limit = 8'h0f;
      2'b11: limit = 8'hff;
      default: limit = 8'h00;
    endcase
  end

  assign pulse = run && (rateSel != 2'b00) && (preCnt_q == limit); // [R5]

  // counter holds while not running, so stop freezes it in place
  always @(posedge clk) begin
    if (sys_rst || clear) begin
      preCnt_q <= 8'h00;
    end else if (run && rateSel != 2'b00) begin
      if (pulse) begin
        preCnt_q <= 8'h00;
      end else begin
        preCnt_q <= preCnt_q + 8'h01;
      end
    end
  end
endmodule // tick_prescaler

//--- hw/tick_watchdog.v
// periodic tick interrupt generator and watchdog timer with register port
`timescale 1ns/10ps
`include "tick_wdog_defs.vh"
module tick_watchdog (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata,
  input wire waitMode,
  input wire stopMode,
  input wire specialMode,
  input wire debugActive,
  input wire debugClockHold,
  output wire irq,
  output wire tickFlag,
  output wire wdogReset
);
  // mode pins come from outside this domain: two-stage synchronisers
  wire [4:0] modeRaw = {debugClockHold, debugActive, specialMode, stopMode, waitMode};
  wire [4:0] modeSync;
  wire waitS = modeSync[0];
  wire stopS = modeSync[1];
  wire specS = modeSync[2];
  wire dbgS = modeSync[3];
  wire holdS = modeSync[4];
  genvar g;

  // one chain per pin; bits may resolve a cycle apart, which the modes tolerate
  generate
    for (g = 0; g < 5; g = g + 1) begin : gen_sync
      reg metaBit_q;
      reg syncBit_q;
      always @(posedge clk) begin
        if (sys_rst) begin
          metaBit_q <= 1'b0;
          syncBit_q <= 1'b0;
        end else begin
          metaBit_q <= modeRaw[g];
          syncBit_q <= metaBit_q;
        end
      end
      assign modeSync[g] = syncBit_q;
    end
  endgenerate

  reg [7:0] tickCtl_q;
  reg [7:0] tickCnt_q;
  reg [7:0] wdogCtl_q;
  reg tickWritten_q;
  reg wdogWritten_q;
  wire [1:0] irqStat;
  reg [1:0] irqMask_q;
  reg rearmState_q;
  reg rearmState_d;
  // rearm machine: key one opens the sequence, key two completes it
  localparam REARM_IDLE = 1'b0;
  localparam REARM_HALF = 1'b1;

  // register select compare, shared by every write decode
  function hitAddr;
    input [7:0] addr;
    input [7:0] target;
    begin
      hitAddr = (addr == target);
    end
  endfunction

  wire wrTickCtl = regWr && hitAddr(regAddr, `ADDR_TICK_CONTROL);
  wire wrTickCnt = regWr && hitAddr(regAddr, `ADDR_TICK_COUNT_SELECT);
  wire wrWdogCtl = regWr && hitAddr(regAddr, `ADDR_WDOG_CONTROL);
  wire wrRearm = regWr && hitAddr(regAddr, `ADDR_WDOG_REARM);
  wire wrStat = regWr && hitAddr(regAddr, `ADDR_IRQ_STATUS);
  wire wrMask = regWr && hitAddr(regAddr, `ADDR_IRQ_MASK);

  // timeout length for a rate code, as a mask of the counter's low bits
  function [15:0] wdogLimit;
    input [2:0] rate;
    begin
      case (rate)
        3'd1: wdogLimit = 16'h003f;
        3'd2: wdogLimit = 16'h00ff;
        3'd3: wdogLimit = 16'h03ff;
        3'd4: wdogLimit = 16'h0fff;
        3'd5: wdogLimit = 16'h3fff;
        3'd6: wdogLimit = 16'h7fff;
        3'd7: wdogLimit = 16'hffff;
        default: wdogLimit = 16'h0000;
      endcase
    end
  endfunction

  // protection: the wait/stop bits take only the first write outside special mode
  wire tickLockOk = specS || !tickWritten_q; // [R3]
  wire wdogLockOk = specS || !wdogWritten_q;
  // a refused control write must not restart the count, or it would feed the dog
  wire wdogCtlTake = wrWdogCtl && wdogLockOk;

  // write-once tracking: any write to a control register closes its lock
  always @(posedge clk) begin
    if (sys_rst) begin
      tickWritten_q <= 1'b0;
      wdogWritten_q <= 1'b0;
    end else begin
      if (wrTickCtl) begin
        tickWritten_q <= 1'b1;
      end
      if (wrWdogCtl) begin
        wdogWritten_q <= 1'b1;
      end
    end
  end

  // tick control: enable and prescale always take the write, mode bits obey the lock
  always @(posedge clk) begin
    if (sys_rst) begin
      tickCtl_q <= `RESET_TICK_CONTROL;
    end else if (wrTickCtl) begin
      tickCtl_q[2:0] <= regWdata[2:0]; // [R8]
      if (tickLockOk) begin
        tickCtl_q[4:3] <= regWdata[4:3]; // [R3]
      end
    end
  end

  // count select; a write here also restarts the tick period
  always @(posedge clk) begin
    if (sys_rst) begin
      tickCnt_q <= `RESET_TICK_COUNT; // [R7]
    end else if (wrTickCnt) begin
      tickCnt_q <= regWdata;
    end
  end

  // watchdog control: bits 4:3 are not implemented and always read zero
  always @(posedge clk) begin
    if (sys_rst) begin
      wdogCtl_q <= `RESET_WDOG_CONTROL;
    end else if (wdogCtlTake) begin
      wdogCtl_q <= {regWdata[7:5], 2'b00, regWdata[2:0]};
    end
  end

  // interrupt mask, same layout as the status register
  always @(posedge clk) begin
    if (sys_rst) begin
      irqMask_q <= 2'b00;
    end else if (wrMask) begin
      irqMask_q <= regWdata[1:0];
    end
  end

  // tick path: freeze in stop unless run-in-stop, clear in wait if stop-in-wait
  wire tickWaitHalt = waitS && tickCtl_q[`TC_STOP_IN_WAIT]; // [R1]
  wire tickStopHold = stopS && !tickCtl_q[`TC_RUN_IN_STOP]; // [R2]
  wire tickOff = (tickCtl_q[1:0] == 2'b00) || (tickCtl_q[1:0] == 2'b01 && tickCnt_q == 8'h00);
  wire tickClear = wrTickCnt || tickWaitHalt || tickOff; // [R7]
  wire tickRun = !tickStopHold && !tickWaitHalt;
  wire prePulse;
  reg [7:0] divCnt_q;
  reg tickEvent;

  tick_prescaler u_pre (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(tickClear),
    .run(tickRun),
    .rateSel(tickCtl_q[1:0]),
    .pulse(prePulse)
  );

  // divide prescaler pulses by count select plus one
  always @* begin
    tickEvent = prePulse && !tickOff && (divCnt_q == tickCnt_q); // [R6]
  end

  reg [7:0] divCnt_d;
  // next divider value: cleared on restart, wraps at each tick, else steps per pulse
  always @* begin
    divCnt_d = divCnt_q;
    if (tickClear || tickEvent) begin
      divCnt_d = 8'h00;
    end else if (prePulse) begin
      divCnt_d = divCnt_q + 8'h01;
    end
  end

  // divider register
  always @(posedge clk) begin
    if (sys_rst) begin
      divCnt_q <= 8'h00;
    end else begin
      divCnt_q <= divCnt_d;
    end
  end

  // watchdog: debug in special mode with hold bit clear forces longest timeout, no window
  wire wdogEn = wdogCtl_q[2:0] != 3'b000;
  wire dbgForce = wdogEn && dbgS && !holdS && specS; // [R14]
  reg [2:0] effRate;
  reg windowOn;
  // debug override forces the longest timeout with the window off
  always @* begin
    if (dbgForce) begin
      effRate = 3'd7; // [R14]
      windowOn = 1'b0;
    end else begin
      effRate = wdogCtl_q[2:0];
      windowOn = wdogCtl_q[`WC_WINDOW];
    end
  end
  wire wdogStopHold = stopS && !wdogCtl_q[`WC_RUN_IN_STOP]; // [R9]
  wire wdogWaitHalt = waitS && wdogCtl_q[`WC_STOP_IN_WAIT];
  reg [15:0] wdogCnt_q;
  reg [15:0] wdogCnt_d;
  reg [3:0] rstCnt_q;
  reg [3:0] rstCnt_d;
  reg [7:0] regRdata_d;
  wire [15:0] lim = wdogLimit(effRate);
  wire wdogExpire = wdogEn && wdogCnt_q == lim && !wdogStopHold && !wdogWaitHalt; // [R12]
  // window mode: rearm allowed only in the last quarter of the period
  wire rearmEarly = windowOn && (wdogCnt_q < (lim - {2'b00, lim[15:2]}));
  wire rearmGood = wrRearm && regWdata == `REARM_KEY2 && rearmState_q == REARM_HALF &&
    !rearmEarly;
  wire rearmBad = wrRearm && !(regWdata == `REARM_KEY1) && !rearmGood;
  wire wdogFire = wdogExpire || (wdogEn && rearmBad);

  // rearm next state: any rearm write other than key one drops back to idle
  always @* begin
    case (rearmState_q)
      REARM_IDLE: begin
        rearmState_d = (wrRearm && regWdata == `REARM_KEY1) ? REARM_HALF : REARM_IDLE;
      end
      REARM_HALF: begin
        if (wrRearm) begin
          rearmState_d = (regWdata == `REARM_KEY1) ? REARM_HALF : REARM_IDLE;
        end else begin
          rearmState_d = REARM_HALF;
        end
      end
      default: begin
        rearmState_d = REARM_IDLE;
      end
    endcase
  end

  // rearm state register
  always @(posedge clk) begin
    if (sys_rst) begin
      rearmState_q <= REARM_IDLE;
    end else begin
      rearmState_q <= rearmState_d; // [R13]
    end
  end

  // next count: restart on accepted control write or rearm, clear while off or in wait with stop-in-wait set
  always @* begin
    wdogCnt_d = wdogCnt_q;
    if (wdogCtlTake || rearmGood || !wdogEn || wdogWaitHalt) begin
      wdogCnt_d = 16'h0000; // [R11]
    end else if (!wdogStopHold) begin
      wdogCnt_d = wdogCnt_q + 16'h0001; // [R10]
    end
  end

  // watchdog count register; stop without run-in-stop simply holds it
  always @(posedge clk) begin
    if (sys_rst) begin
      wdogCnt_q <= 16'h0000;
    end else begin
      wdogCnt_q <= wdogCnt_d; // [R9]
    end
  end

  // reset request stretched so the reset generator is sure to see it
  always @* begin
    rstCnt_d = rstCnt_q;
    if (wdogFire) begin
      rstCnt_d = `WDOG_RESET_PULSE; // [R12]
    end else if (rstCnt_q != 4'h0) begin
      rstCnt_d = rstCnt_q - 4'h1;
    end
  end

  // pulse length counter
  always @(posedge clk) begin
    if (sys_rst) begin
      rstCnt_q <= 4'h0;
    end else begin
      rstCnt_q <= rstCnt_d;
    end
  end
  assign wdogReset = rstCnt_q != 4'h0;

  // sticky status, one bit per source; a new event wins over a write-one clear
  wire [1:0] irqEvent = {wdogFire, tickEvent};
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_stat
      reg statBit_q;
      always @(posedge clk) begin
        if (sys_rst) begin
          statBit_q <= 1'b0; // [R15]
        end else begin
          statBit_q <= irqEvent[g] || (statBit_q && !(wrStat && regWdata[g])); // [R15]
        end
      end
      assign irqStat[g] = statBit_q;
    end
  endgenerate
  assign tickFlag = irqStat[`IRQ_TICK];

  // request per source; the tick needs both its own enable and its mask bit
  reg irqTick;
  reg irqWdog;
  always @* begin
    irqTick = irqStat[`IRQ_TICK] && tickCtl_q[`TC_IRQ_ENABLE] && irqMask_q[`IRQ_TICK]; // [R4]
    irqWdog = irqStat[`IRQ_WDOG] && irqMask_q[`IRQ_WDOG];
  end
  assign irq = irqTick || irqWdog;

  // read mux; idle cycles and unmapped addresses give zero
  always @* begin
    regRdata_d = 8'h00;
    if (regRd) begin
      case (regAddr)
        `ADDR_TICK_CONTROL: regRdata_d = {3'b000, tickCtl_q[4:0]};
        `ADDR_TICK_COUNT_SELECT: regRdata_d = tickCnt_q;
        `ADDR_WDOG_CONTROL: regRdata_d = wdogCtl_q;
        `ADDR_IRQ_STATUS: regRdata_d = {6'h00, irqStat};
        `ADDR_IRQ_MASK: regRdata_d = {6'h00, irqMask_q};
        default: regRdata_d = 8'h00;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= regRdata_d;
    end
  end
endmodule // tick_watchdog

//--- tb/tick_wdog_asserts.sv
// port checks for the tick and watchdog block
`timescale 1ns/10ps
module tick_wdog_asserts (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regRdata,
  input wire irq,
  input wire tickFlag,
  input wire wdogReset
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  reg [7:0] cntQ;
  reg [1:0] presQ;
  reg [1:0] maskQ;
  reg enQ;
  wire wrTc = regWr && regAddr == 8'h3b;
  // shadow of the always-writable fields, so irq can be judged from the bus alone
  always @(posedge clk) begin
    if (sys_rst) begin
      cntQ <= 8'h00;
      presQ <= 2'h0;
      maskQ <= 2'h0;
      enQ <= 1'b0;
    end else begin
      if (regWr && regAddr == 8'h3d) cntQ <= regWdata;
      if (wrTc) presQ <= regWdata[1:0];
      if (wrTc) enQ <= regWdata[2];
      if (regWr && regAddr == 8'h41) maskQ <= regWdata[1:0];
    end
  end
  // reset pulse: eight cycles high, then low
  sequence pulseS;
    wdogReset [*8] ##1 !wdogReset;
  endsequence
  rd_idle_a: assert property (!regRd |=> regRdata == 8'h00) else $error("rdata");
  cnt_read_a: assert property (regRd && regAddr == 8'h3d |=> regRdata == cntQ)
    else $error("count readback");
  rst_clear_a: assert property ($fell(sys_rst) |-> !tickFlag && !irq && !wdogReset)
    else $error("outputs after reset");
  flag_sticky_a: assert property (tickFlag && !(regWr && regAddr == 8'h40 && regWdata[0])
    |=> tickFlag) else $error("flag lost");
  rst_pulse_a: assert property ($rose(wdogReset) |-> pulseS) else $error("pulse");
  irq_tick_a: assert property (tickFlag && enQ && maskQ[0] |-> irq) else $error("irq");
  irq_off_a: assert property (!(enQ && maskQ[0]) && !maskQ[1] |-> !irq)
    else $error("irq masked");
  tick_off_a: assert property (presQ == 2'h0 && $past(presQ, 3) == 2'h0 && !tickFlag
    |=> !tickFlag) else $error("tick off");
endmodule // tick_wdog_asserts

bind tick_watchdog tick_wdog_asserts chk_u (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
  .tickFlag(tickFlag), .wdogReset(wdogReset));

//--- tb/tb_top.sv
// self-checking bench for the tick and watchdog block
`timescale 1ns/10ps
module tb_top;
  reg clk, sys_rst, regWr, regRd, waitMode, stopMode, specialMode, dbgAct, dbgHold;
  reg [7:0] regAddr, regWdata;
  wire [7:0] regRdata;
  wire irq, tickFlag, wdogReset;
  integer err_total, compares, i, n, t;
  time t0;
  tick_watchdog dut_u (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .waitMode(waitMode),
    .stopMode(stopMode), .specialMode(specialMode), .debugActive(dbgAct),
    .debugClockHold(dbgHold), .irq(irq), .tickFlag(tickFlag), .wdogReset(wdogReset));
  task chk(input [15:0] got, input [15:0] exp, input string msg);
    compares = compares + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("wrong value %0t %s: %0d vs %0d", $time, msg, got, exp);
    end
  endtask
  // strobe drops with an edge in between, so back-to-back calls never collide
  task wr(input [7:0] a, input [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input [7:0] a, input [7:0] exp, input string msg);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp, msg);
    @(posedge clk);
  endtask
  task rst;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask
  // bounded wait, sampled at the falling edge where outputs have settled
  task waitHi(input sel, input integer lim, output integer c);
    c = 0;
    while ((sel ? wdogReset : tickFlag) !== 1'b1 && c < lim) begin
      @(negedge clk);
      c = c + 1;
    end
    @(posedge clk);
  endtask
  function [15:0] per(input [15:0] p, input [15:0] c);
    per = (c + 1) * (p == 1 ? 1 : p == 2 ? 16 : 256);
  endfunction
  task finish_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // cut a hang well beyond the longest expected run
  initial begin
    #(60000 * 25);
    err_total = err_total + 1;
    finish_test;
  end
  initial begin
    {err_total, compares} = 0;
    {regAddr, regWdata, regWr, regRd, waitMode, stopMode, specialMode, dbgAct, dbgHold} = 0;
    sys_rst = 1'b1;
    i = $urandom(32'h5e595d9e);
    rst;
    rd(8'h3d, 8'h00, "cnt reset");
    rd(8'h50, 8'h00, "unmapped");
    // every prescaler with a random count; period measured between two flags
    for (i = 1; i < 4; i = i + 1) begin
      n = 3 + $urandom % 20;
      rst;
      wr(8'h41, 8'h01);
      wr(8'h3b, 8'h04 | i[7:0]);
      wr(8'h3d, n[7:0]);
      waitHi(0, 9000, t);
      t0 = $time;
      chk(irq, 1, "irq");
      wr(8'h40, 8'h01);
      chk(tickFlag, 0, "w1c");
      waitHi(0, 9000, t);
      chk(16'(($time - t0) / 25), per(i, n), "period");
    end
    $display("tick periods done");
    rst;
    wr(8'h3b, 8'h01);
    wr(8'h3d, 8'd40);
    repeat (20) @(posedge clk);
    wr(8'h3d, 8'd9);
    waitHi(0, 60, t);
    chk(t >= 6 && t <= 13, 1, "restart");
    rst;
    wr(8'h3b, 8'h11);
    wr(8'h3b, 8'h09);
    rd(8'h3b, 8'h11, "once");
    wr(8'h3d, 8'h09);
    waitMode <= 1'b1;
    repeat (4) @(posedge clk);
    wr(8'h40, 8'h01);
    waitHi(0, 100, t);
    chk(tickFlag, 0, "wait halt");
    waitMode <= 1'b0;
    waitHi(0, 30, t);
    chk(t >= 9 && t <= 16, 1, "wait reinit");
    stopMode <= 1'b1;
    repeat (4) @(posedge clk);
    wr(8'h40, 8'h01);
    waitHi(0, 100, t);
    chk(tickFlag, 0, "stop freeze");
    specialMode <= 1'b1;
    repeat (4) @(posedge clk);
    wr(8'h3b, 8'h09);
    rd(8'h3b, 8'h09, "special");
    waitHi(0, 40, t);
    chk(tickFlag, 1, "stop run");
    $display("modes done");
    {stopMode, specialMode} <= 2'b00;
    for (i = 1; i < 5; i = i + 1) begin
      rst;
      wr(8'h3c, i[7:0]);
      waitHi(1, 5000, t);
      chk(t + 4 >= (1 << (2 * i + 4)) && t <= (1 << (2 * i + 4)), 1, "timeout");
    end
    rst;
    wr(8'h3c, 8'h01);
    for (i = 0; i < 5; i = i + 1) begin
      waitHi(1, 40, t);
      chk(t, 40, "rearm");
      wr(8'h3f, 8'h55);
      wr(8'h3f, 8'haa);
    end
    wr(8'h3f, 8'h12);
    waitHi(1, 4, t);
    chk(wdogReset, 1, "bad key");
    chk(irq, 0, "masked");
    rd(8'h40, 8'h02, "status");
    wr(8'h41, 8'h02);
    chk(irq, 1, "unmasked");
    repeat (10) @(posedge clk);
    wr(8'h40, 8'h02);
    chk(irq, 0, "cleared");
    // debug in special mode overrides a short rate; the hold bit cancels that
    {specialMode, dbgAct} <= 2'b11;
    rst;
    repeat (3) @(posedge clk);
    wr(8'h3c, 8'h01);
    waitHi(1, 300, t);
    chk(wdogReset, 0, "debug force");
    dbgHold <= 1'b1;
    rst;
    repeat (3) @(posedge clk);
    wr(8'h3c, 8'h01);
    waitHi(1, 100, t);
    chk(wdogReset, 1, "hold bit");
    {specialMode, dbgAct, dbgHold} <= 3'b000;
    rst;
    repeat (3) @(posedge clk);
    wr(8'h3c, 8'h01);
    stopMode <= 1'b1;
    waitHi(1, 200, t);
    chk(wdogReset, 0, "wdog stop hold");
    stopMode <= 1'b0;
    waitHi(1, 100, t);
    chk(t >= 50 && t <= 70, 1, "wdog resume");
    $display("watchdog done");
    finish_test;
  end
endmodule // tb_top
